//--- rtl/frame_trigger_pkg.sv
// constants shared by both ends of the frame sync trigger link
package frame_trigger_pkg;
  // ===========================================
  // clock
  localparam int CLK_PERIOD_NS = 10;
  // ===========================================
  // device timing
  localparam int TRIGGER_LATENCY_NS = 160;
  localparam int TRIGGER_LATENCY_CYC =
    (TRIGGER_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 : (TRIGGER_LATENCY_NS / CLK_PERIOD_NS);
  localparam int SYNC_STAGES = 2;
  // ===========================================
  // host pulse limits
  localparam int PULSE_MIN_NS = 25;
  localparam int PULSE_MAX_NS = 4000;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYC = (PULSE_MAX_NS - 1) / CLK_PERIOD_NS;
  // ===========================================
  // widths and defaults
  localparam int DELAY_W = 16;
  localparam int COUNT_W = 16;
  localparam int CHIRP_W = 8;
  localparam int BURST_W = 8;
  localparam int CHIRP_LEN_DEF = 16;
  localparam int CHIRPS_DEF = 4;
  localparam int BURSTS_DEF = 2;
endpackage

//--- rtl/frame_sync_if.sv
// link between host sync source and device frame trigger
`timescale 1ns/100ps
`default_nettype none
interface frame_sync_if;
  logic frame_sync;
  modport host_mp (output frame_sync);
  modport dev_mp  (input  frame_sync);
endinterface
`default_nettype wire

//--- rtl/frame_trigger_dev.sv
// device end: synchronised sync edge starts a frame from the timing engine when armed and idle
`timescale 1ns/100ps
`default_nettype none
module frame_trigger_dev #(
  parameter int DELAY_W = frame_trigger_pkg::DELAY_W,
  parameter int COUNT_W = frame_trigger_pkg::COUNT_W,
  parameter int CHIRP_W = frame_trigger_pkg::CHIRP_W,
  parameter int BURST_W = frame_trigger_pkg::BURST_W
) (
  // clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  // link
  frame_sync_if.dev_mp            link,
  // software control
  input  wire logic               arm_in,
  input  wire logic               disarm_in,
  input  wire logic [DELAY_W-1:0] user_delay_in,
  input  wire logic [COUNT_W-1:0] chirp_len_in,
  input  wire logic [CHIRP_W-1:0] chirps_per_burst_in,
  input  wire logic [BURST_W-1:0] bursts_per_frame_in,
  // status
  output logic                    armed_out,
  output logic                    frame_active_out,
  output logic                    frame_start_out,
  output logic                    chirp_start_out,
  output logic                    burst_start_out,
  output logic                    frame_done_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CHIRP} trig_state_e;

  // ===========================================
  // input synchroniser
  logic [frame_trigger_pkg::SYNC_STAGES-1:0] sync_ff;
  logic                                      sync_prev;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_ff   <= '0;
      sync_prev <= 1'b0;
    end else begin
      sync_ff   <= {sync_ff[0], link.frame_sync};
      sync_prev <= sync_ff[1];
    end
  end
  wire logic rise = sync_ff[1] & ~sync_prev;

  // ===========================================
  // trigger and timing engine
  localparam int LAT = frame_trigger_pkg::TRIGGER_LATENCY_CYC - frame_trigger_pkg::SYNC_STAGES;
  localparam int WAIT_W = DELAY_W + 2;

  trig_state_e          state, next_state;
  logic                 armed, next_armed;
  logic [WAIT_W-1:0]    wait_cnt, next_wait_cnt;
  logic [COUNT_W-1:0]   len_cnt, next_len_cnt;
  logic [CHIRP_W-1:0]   chirp_cnt, next_chirp_cnt;
  logic [BURST_W-1:0]   burst_cnt, next_burst_cnt;
  logic                 next_fs, next_cs, next_bs, next_fd;

  always_comb begin
    next_state     = state;
    next_armed     = armed;
    next_wait_cnt  = wait_cnt;
    next_len_cnt   = len_cnt;
    next_chirp_cnt = chirp_cnt;
    next_burst_cnt = burst_cnt;
    next_fs        = 1'b0;
    next_cs        = 1'b0;
    next_bs        = 1'b0;
    next_fd        = 1'b0;
    if (arm_in) begin
      next_armed = 1'b1;
    end else if (disarm_in) begin
      next_armed = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (rise && armed) begin
          next_wait_cnt = WAIT_W'(LAT - 1) + WAIT_W'(user_delay_in);
          next_state    = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_cnt == '0) begin
          next_state     = ST_CHIRP;
          next_fs        = 1'b1;
          next_cs        = 1'b1;
          next_bs        = 1'b1;
          next_len_cnt   = '0;
          next_chirp_cnt = '0;
          next_burst_cnt = '0;
        end else begin
          next_wait_cnt = wait_cnt - 1'b1;
        end
      end
      ST_CHIRP: begin
        if (len_cnt + 1'b1 < chirp_len_in) begin
          next_len_cnt = len_cnt + 1'b1;
        end else begin
          next_len_cnt = '0;
          if (chirp_cnt + 1'b1 < chirps_per_burst_in) begin
            next_chirp_cnt = chirp_cnt + 1'b1;
            next_cs        = 1'b1;
          end else begin
            next_chirp_cnt = '0;
            if (burst_cnt + 1'b1 < bursts_per_frame_in) begin
              next_burst_cnt = burst_cnt + 1'b1;
              next_cs        = 1'b1;
              next_bs        = 1'b1;
            end else begin
              next_fd    = 1'b1;
              next_state = ST_IDLE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state           <= ST_IDLE;
      armed           <= 1'b0;
      wait_cnt        <= '0;
      len_cnt         <= '0;
      chirp_cnt       <= '0;
      burst_cnt       <= '0;
      frame_start_out <= 1'b0;
      chirp_start_out <= 1'b0;
      burst_start_out <= 1'b0;
      frame_done_out  <= 1'b0;
    end else begin
      state           <= next_state;
      armed           <= next_armed;
      wait_cnt        <= next_wait_cnt;
      len_cnt         <= next_len_cnt;
      chirp_cnt       <= next_chirp_cnt;
      burst_cnt       <= next_burst_cnt;
      frame_start_out <= next_fs;
      chirp_start_out <= next_cs;
      burst_start_out <= next_bs;
      frame_done_out  <= next_fd;
    end
  end

  assign armed_out        = armed;
  assign frame_active_out = (state != ST_IDLE);
endmodule
`default_nettype wire

//--- rtl/frame_sync_host.sv
// host end: emits sync pulses of programmed width, clamped to the host pulse limits, and period
`timescale 1ns/100ps
`default_nettype none
module frame_sync_host #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  // link
  frame_sync_if.host_mp         link,
  // user control
  input  wire logic             run_in,
  input  wire logic [CNT_W-1:0] width_cyc_in,
  input  wire logic [CNT_W-1:0] period_cyc_in,
  // status
  output logic                  pulse_sent_out
);
  localparam logic [CNT_W-1:0] W_MIN = CNT_W'(frame_trigger_pkg::PULSE_MIN_CYC);
  localparam logic [CNT_W-1:0] W_MAX = CNT_W'(frame_trigger_pkg::PULSE_MAX_CYC);

  // ===========================================
  // pulse generator
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] sync_pulse_width;
  logic             sync_q, next_sync_q, next_sent;

  always_comb begin
    if (width_cyc_in < W_MIN) begin
      sync_pulse_width = W_MIN;
    end else if (width_cyc_in > W_MAX) begin
      sync_pulse_width = W_MAX;
    end else begin
      sync_pulse_width = width_cyc_in;
    end
  end

  always_comb begin
    next_cnt    = cnt;
    next_sync_q = 1'b0;
    next_sent   = 1'b0;
    if (run_in || cnt != '0) begin
      if (cnt + 1'b1 >= period_cyc_in && cnt + 1'b1 > sync_pulse_width) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
      next_sync_q = (next_cnt != '0) && (next_cnt <= sync_pulse_width);
      next_sent   = (cnt == '0) && run_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt            <= '0;
      sync_q         <= 1'b0;
      pulse_sent_out <= 1'b0;
    end else begin
      cnt            <= next_cnt;
      sync_q         <= next_sync_q;
      pulse_sent_out <= next_sent;
    end
  end

  assign link.frame_sync = sync_q;
endmodule
`default_nettype wire

//--- testbench/frame_trigger_checker.sv
// assertions on the frame sync link and device status
`timescale 1ns/100ps
`default_nettype none
module frame_trigger_checker (
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  // link and status
  input wire logic        frame_sync,
  input wire logic [15:0] user_delay_in,
  input wire logic        armed_out,
  input wire logic        frame_active_out,
  input wire logic        frame_start_out,
  input wire logic        chirp_start_out,
  input wire logic        burst_start_out,
  input wire logic        frame_done_out,
  input wire logic        pulse_sent_out
);
  // ===========================================
  // properties
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence rise_armed;
    $rose(frame_sync) && armed_out && !frame_active_out;
  endsequence
  sequence rise_unarmed;
    $rose(frame_sync) && !armed_out && !frame_active_out;
  endsequence
  a_zero_delay: assert property (rise_armed ##0 user_delay_in == 16'h0 |-> ##17 frame_start_out)
    else $error("start latency wrong");
  a_added_delay: assert property (rise_armed ##0 user_delay_in == 16'h3 |-> ##20 frame_start_out)
    else $error("start delay wrong");
  a_no_early: assert property (rise_armed |-> ##1 !frame_start_out [*8])
    else $error("frame started early");
  a_edge_starts: assert property (rise_armed |-> ##3 frame_active_out)
    else $error("edge did not start frame");
  a_unarmed_drop: assert property (rise_unarmed |-> ##3 !frame_active_out)
    else $error("unarmed edge started frame");
  a_needs_arm: assert property ($rose(frame_active_out) |-> $past(armed_out))
    else $error("frame without arming");
  a_start_shape: assert property (frame_start_out |-> chirp_start_out && burst_start_out)
    else $error("frame start without chirp");
  a_done_ends: assert property (frame_done_out |-> !frame_active_out && !$past(frame_done_out))
    else $error("frame done wrong");
  a_host_width: assert property ($rose(frame_sync) |-> frame_sync [*3])
    else $error("sync pulse too short");
  a_sent_marks: assert property (pulse_sent_out |-> $rose(frame_sync))
    else $error("pulse flag without edge");
endmodule
`default_nettype wire

//--- testbench/test_hw_sync_frame_trigger.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_hw_sync_frame_trigger;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        arm_in = 1'b0, disarm_in = 1'b0, run_in = 1'b0;
  logic [15:0] user_delay_in = 16'h0;
  logic [31:0] width_cyc = 32'h5;
  logic        armed_out, frame_active_out, frame_start_out, chirp_start_out;
  logic        burst_start_out, frame_done_out, pulse_sent_out;
  int          fail_count = 0, compares = 0;
  frame_sync_if link ();
  always #5 core_clk_in = ~core_clk_in;
  frame_sync_host frame_sync_host_inst (.core_clk_in, .rst_in, .link(link.host_mp), .run_in,
    .width_cyc_in(width_cyc), .period_cyc_in(32'h3E8), .pulse_sent_out);
  frame_trigger_dev frame_trigger_dev_inst (.core_clk_in, .rst_in, .link(link.dev_mp), .arm_in,
    .disarm_in, .user_delay_in, .chirp_len_in(16'h4), .chirps_per_burst_in(8'h2),
    .bursts_per_frame_in(8'h2), .armed_out, .frame_active_out, .frame_start_out,
    .chirp_start_out, .burst_start_out, .frame_done_out);
  frame_trigger_checker frame_trigger_checker_inst (.core_clk_in, .rst_in,
    .frame_sync(link.frame_sync), .user_delay_in, .armed_out, .frame_active_out,
    .frame_start_out, .chirp_start_out, .burst_start_out, .frame_done_out, .pulse_sent_out);
  // ===========================================
  // tasks
  task step;
    @(posedge core_clk_in);
    #1;
  endtask
  task close_out;
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_unarmed;
    int w, s;
    w = 0;
    s = 0;
    width_cyc = 32'h1;
    run_in = 1'b1;
    step;
    run_in = 1'b0;
    repeat (40) begin
      w += link.frame_sync;
      s += frame_start_out;
      step;
    end
    `CHK(w, 3)
    `CHK(s, 0)
    `CHK(armed_out, 1'b0)
  endtask
  task automatic t_frame(input logic [15:0] d);
    int lat, ch, bu;
    lat = 0;
    ch = 0;
    bu = 0;
    user_delay_in = d;
    width_cyc = 32'h5;
    arm_in = 1'b1;
    step;
    arm_in = 1'b0;
    `CHK(armed_out, 1'b1)
    run_in = 1'b1;
    while (pulse_sent_out !== 1'b1 && lat < 1100) begin
      lat++;
      step;
    end
    run_in = 1'b0;
    lat = 0;
    while (frame_start_out !== 1'b1 && lat < 300) begin
      lat++;
      step;
    end
    `CHK(lat, 17 + d)
    while (frame_done_out !== 1'b1) begin
      ch += chirp_start_out;
      bu += burst_start_out;
      step;
    end
    `CHK(ch, 4)
    `CHK(bu, 2)
    `CHK(frame_active_out, 1'b0)
    disarm_in = 1'b1;
    step;
    disarm_in = 1'b0;
    `CHK(armed_out, 1'b0)
  endtask
  // ===========================================
  // sequence and watchdog
  initial begin
    repeat (5) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    step;
    t_unarmed;
    t_frame(16'h0);
    t_frame(16'h3);
    close_out;
  end
  initial begin
    #40000;
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
